// ==== common/pd_decoder_pkg.sv ====
package pd_decoder_pkg;

   localparam int WORD_W = 16;

   // control word field positions
   localparam int CTL_RUN_BIT   = 0;
   localparam int CTL_DIR_BIT   = 1;
   localparam int CTL_RAMP_BIT  = 2;
   localparam int CTL_RESET_BIT = 6;
   localparam logic [2:0] CTL_ENABLE_PAT = 3'h6;

   // ramp limits in milliseconds
   localparam logic [15:0] RAMP_MIN_MS = 16'h0064;
   localparam logic [15:0] RAMP_MAX_MS = 16'h2710;

   // speed full-scale codes
   localparam logic [15:0] SPEED_FULL_CW  = 16'h4000;
   localparam logic [15:0] SPEED_FULL_CCW = 16'hc000;

   // reset values
   localparam logic [15:0] SPEED_RST = 16'h0000;
   localparam logic [15:0] RAMP_RST  = 16'h03e8;

   // avalon register offsets
   localparam logic [3:0] REG_CONFIG  = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_SPEED   = 4'h8;
   localparam logic [3:0] REG_RAMP    = 4'hc;
   localparam int CFG_THREE_BIT = 0;

   typedef struct packed {
      logic [15:0] control_out_word;
      logic [15:0] speed_out_word;
      logic [15:0] ramp_out_word;
   } out_words_t;

   typedef struct packed {
      logic [15:0] status_in_word_first;
      logic [15:0] current_in_word;
      logic [15:0] status_in_word_second;
   } in_words_t;

   typedef struct packed {
      logic        enable;
      logic        stop;
      logic        fault_ack;
      logic [15:0] speed;
      logic [15:0] ramp_ms;
   } drive_cmd_t;

endpackage : pd_decoder_pkg

// ==== src/ramp_clamp.sv ====
`timescale 1ns/1ns
`default_nettype none
module ramp_clamp
(
   input  wire logic [15:0] ramp_in,
   output logic      [15:0] ramp_out
);
   always_comb
   begin
      if (ramp_in < pd_decoder_pkg::RAMP_MIN_MS)
         ramp_out = pd_decoder_pkg::RAMP_MIN_MS;
      else if (ramp_in > pd_decoder_pkg::RAMP_MAX_MS)
         ramp_out = pd_decoder_pkg::RAMP_MAX_MS;
      else
         ramp_out = ramp_in;
   end
endmodule : ramp_clamp
`default_nettype wire

// ==== src/drive_process_data_decoder.sv ====
// What this block does
// - supports two-word and three-word process data
// - two words: control, speed; status1, current
// - three words add ramp out, status2 in
// - ignore output words while address is zero
// - low three bits 110 mean enable
// - enable needs a direction terminal asserted
// - bit 2 zero stops on current ramp
// - control bit 6 acknowledges a present fault
// - speed signed, 4000 full cw, c000 ccw
// - three words: third word is ramp ms
// - two words: ramp from local selector switch
`timescale 1ns/1ns
`default_nettype none
module drive_process_data_decoder
(
   input  wire logic                      clk_in,
   input  wire logic                      resetn_in,
   input  wire logic                      pd_valid_in,
   input  wire pd_decoder_pkg::out_words_t pd_out_words_in,
   input  wire logic [15:0]               status_first_in,
   input  wire logic [15:0]               output_current_in,
   input  wire logic [15:0]               status_second_in,
   input  wire logic [3:0]                address_switch_in,
   input  wire logic [15:0]               ramp_selector_switch_in,
   input  wire logic                      clockwise_terminal_in,
   input  wire logic                      counterclockwise_terminal_in,
   input  wire logic                      fault_in,
   input  wire logic [3:0]                avs_address_in,
   input  wire logic                      avs_read_in,
   input  wire logic                      avs_write_in,
   input  wire logic [31:0]               avs_writedata_in,
   input  wire logic [3:0]                avs_byteenable_in,
   output logic      [31:0]               avs_readdata_out,
   output logic                           avs_waitrequest_out,
   output pd_decoder_pkg::in_words_t      pd_in_words_out,
   output pd_decoder_pkg::drive_cmd_t     drive_cmd_out,
   output logic                           fault_clear_out
);

   // one-cycle wait gives registered read data with a clean handshake
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } bus_state_t;

   bus_state_t                  bus_q, bus_d;
   logic                        three_q, three_d;
   logic [31:0]                 rdata_q, rdata_d;
   pd_decoder_pkg::drive_cmd_t  cmd_q, cmd_d;
   pd_decoder_pkg::in_words_t   inw_q, inw_d;
   logic                        fclr_q, fclr_d;
   logic [15:0]                 clamped_ramp;
   logic [15:0]                 ctl;
   logic                        addr_ok;
   logic                        dir_ok;
   logic                        take;

   // zero-extends a returned word onto the 32-bit bus
   function automatic logic [31:0] zext16(input logic [15:0] v);
      zext16 = {16'h0000, v};
   endfunction : zext16

   // only bits 0..2 count, so special-function bits cannot enable
   function automatic logic enable_pat(input logic [15:0] c);
      enable_pat = (c[2:0] == pd_decoder_pkg::CTL_ENABLE_PAT);
   endfunction : enable_pat

   function automatic logic stop_req(input logic [15:0] c);
      stop_req = ~c[pd_decoder_pkg::CTL_RAMP_BIT];
   endfunction : stop_req

   function automatic logic reset_req(input logic [15:0] c);
      reset_req = c[pd_decoder_pkg::CTL_RESET_BIT];
   endfunction : reset_req

   function automatic logic [31:0] status_word
   (
      input logic [3:0] addr,
      input logic       ack,
      input logic       stop,
      input logic       enable,
      input logic       gate
   );
      status_word = {24'h00_0000, addr, ack, stop, enable, gate};
   endfunction : status_word

   // unmapped offsets read as zero
   function automatic logic [31:0] reg_read
   (
      input logic [3:0]  addr,
      input logic        three,
      input logic [31:0] status,
      input logic [15:0] speed,
      input logic [15:0] ramp
   );
      unique case (addr)
         pd_decoder_pkg::REG_CONFIG:
            reg_read = {31'h0000_0000, three};
         pd_decoder_pkg::REG_STATUS:
            reg_read = status;
         pd_decoder_pkg::REG_SPEED:
            reg_read = zext16(speed);
         pd_decoder_pkg::REG_RAMP:
            reg_read = zext16(ramp);
         default:
            reg_read = 32'h0000_0000;
      endcase
   endfunction : reg_read

   ramp_clamp u_clamp
   (
      .ramp_in  (pd_out_words_in.ramp_out_word),
      .ramp_out (clamped_ramp)
   );

   assign ctl     = pd_out_words_in.control_out_word;
   assign addr_ok = (address_switch_in != 4'h0);
   assign dir_ok  = clockwise_terminal_in | counterclockwise_terminal_in;
   assign take    = pd_valid_in && addr_ok;

   // fault clear pulses once per accepted frame with control bit 6 set and a fault present
   always_comb
   begin
      fclr_d = 1'b0;
      if (take && reset_req(ctl) && fault_in)
         fclr_d = 1'b1;
   end

   // decoder; reserved bits 3..5 and 7..15 are never looked at
   always_comb
   begin
      cmd_d           = cmd_q;
      cmd_d.fault_ack = 1'b0;
      if (take)
      begin
         cmd_d.stop      = stop_req(ctl);
         cmd_d.enable    = enable_pat(ctl) && dir_ok;
         cmd_d.speed     = pd_out_words_in.speed_out_word;
         cmd_d.fault_ack = fclr_d;
      end
      // enable drops on the next clock edge when both terminals release, without waiting for a frame
      if (!dir_ok)
      begin
         cmd_d.enable = 1'b0;
      end
      if (three_q)
      begin
         if (take)
            cmd_d.ramp_ms = clamped_ramp;
      end
      else
      begin
         cmd_d.ramp_ms = ramp_selector_switch_in;
      end
   end

   // returned words; third word is zero in two-word mode
   always_comb
   begin
      inw_d.status_in_word_first = status_first_in;
      inw_d.current_in_word      = output_current_in;
      if (three_q)
      begin
         inw_d.status_in_word_second = status_second_in;
      end
      else
      begin
         inw_d.status_in_word_second = 16'h0000;
      end
   end

   // avalon slave; one wait cycle, no back-pressure beyond it
   always_comb
   begin
      bus_d = bus_q;
      unique case (bus_q)
         BUS_IDLE:
         begin
            if (avs_read_in || avs_write_in)
               bus_d = BUS_DONE;
         end
         BUS_DONE:
         begin
            bus_d = BUS_IDLE;
         end
         default:
         begin
            bus_d = BUS_IDLE;
         end
      endcase
   end

   // config bit; a write lacking byte lane 0 is dropped
   always_comb
   begin
      three_d = three_q;
      if (bus_q == BUS_IDLE && avs_write_in && !avs_read_in &&
          avs_byteenable_in[0] &&
          avs_address_in == pd_decoder_pkg::REG_CONFIG)
         three_d = avs_writedata_in[pd_decoder_pkg::CFG_THREE_BIT];
   end

   // read data captured in the wait cycle, held until the next read
   always_comb
   begin
      rdata_d = rdata_q;
      if (bus_q == BUS_IDLE && avs_read_in)
         rdata_d = reg_read(avs_address_in, three_q,
                            status_word(address_switch_in,
                                        cmd_q.fault_ack, cmd_q.stop,
                                        cmd_q.enable, addr_ok),
                            cmd_q.speed, cmd_q.ramp_ms);
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         bus_q <= BUS_IDLE;
      end
      else
      begin
         bus_q <= bus_d;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         three_q <= 1'b0;
      end
      else
      begin
         three_q <= three_d;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // stopped and disabled until the first accepted frame
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         cmd_q <= '{enable: 1'b0, stop: 1'b1, fault_ack: 1'b0,
                    speed: pd_decoder_pkg::SPEED_RST,
                    ramp_ms: pd_decoder_pkg::RAMP_RST};
      end
      else
      begin
         cmd_q <= cmd_d;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         inw_q <= '0;
      end
      else
      begin
         inw_q <= inw_d;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         fclr_q <= 1'b0;
      end
      else
      begin
         fclr_q <= fclr_d;
      end
   end

   assign avs_waitrequest_out = (avs_read_in || avs_write_in) &&
                                (bus_q == BUS_IDLE);
   assign avs_readdata_out    = rdata_q;
   assign pd_in_words_out     = inw_q;
   assign drive_cmd_out       = cmd_q;
   assign fault_clear_out     = fclr_q;

endmodule : drive_process_data_decoder
`default_nettype wire

// ==== tb/drive_process_data_decoder_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module drive_process_data_decoder_monitor
(
   input wire logic                       clk_in,
   input wire logic                       resetn_in,
   input wire logic                       pd_valid_in,
   input wire pd_decoder_pkg::out_words_t pd_out_words_in,
   input wire logic [3:0]                 address_switch_in,
   input wire logic                       clockwise_terminal_in,
   input wire logic                       counterclockwise_terminal_in,
   input wire logic                       fault_in,
   input wire logic                       avs_read_in,
   input wire logic                       avs_write_in,
   input wire logic                       avs_waitrequest_out,
   input wire pd_decoder_pkg::drive_cmd_t drive_cmd_out,
   input wire logic                       fault_clear_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   wire logic        dir = clockwise_terminal_in | counterclockwise_terminal_in;
   wire logic [15:0] ctl = pd_out_words_in.control_out_word;
   wire logic        ok  = pd_valid_in && address_switch_in != 4'h0;
   sequence s_take;
      ok;
   endsequence
   sequence s_ack;
      s_take ##0 (ctl[6] && fault_in);
   endsequence
   a_addr_gate: assert property (
      pd_valid_in && !ok |=> $stable(drive_cmd_out.speed))
      else $error("speed moved while address zero");
   a_enable_cmd: assert property (
      s_take ##0 (ctl[2:0] == 3'h6 && dir) |=> drive_cmd_out.enable)
      else $error("enable pattern not taken");
   a_dir_needed: assert property (
      !dir |=> !drive_cmd_out.enable)
      else $error("enable without direction terminal");
   a_stop_bit: assert property (
      s_take ##0 !ctl[2] |=> drive_cmd_out.stop && !drive_cmd_out.enable)
      else $error("bit 2 low did not stop");
   a_fault_clear: assert property (
      s_ack |=> fault_clear_out && drive_cmd_out.fault_ack)
      else $error("fault not acknowledged");
   a_no_stray: assert property (
      fault_clear_out |-> $past(ok && ctl[6] && fault_in))
      else $error("fault clear without cause");
   a_speed_word: assert property (
      s_take |=> drive_cmd_out.speed == $past(pd_out_words_in.speed_out_word))
      else $error("speed word not passed");
   a_bus_answer: assert property (
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("bus answer late");
endmodule : drive_process_data_decoder_monitor
bind drive_process_data_decoder drive_process_data_decoder_monitor u_mon (.*);
`default_nettype wire

// ==== tb/fieldbus_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model
(
   input  wire logic                      clk_in,
   output var pd_decoder_pkg::out_words_t words_out,
   output logic                           valid_out
);
   initial
   begin
      valid_out = 1'b0;
      words_out = '0;
   end
   task automatic send(input logic [15:0] c, s, r);
      @(posedge clk_in);
      valid_out <= 1'b1;
      words_out <= {c, s, r};
      @(posedge clk_in);
      valid_out <= 1'b0;
      words_out <= ~{c, s, r}; // idle lines must not echo the frame
      #1;
   endtask : send
   task automatic stop();
      send(16'h0002, 16'h0000, 16'h0000);
   endtask : stop
endmodule : fieldbus_master_model
`default_nettype wire

// ==== tb/drive_process_data_decoder_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module drive_process_data_decoder_test;
   logic        clk_in = 1'b0, resetn_in = 1'b0, pd_valid_in, fault_in = 1'b0;
   logic        clockwise_terminal_in = 1'b1;
   logic        counterclockwise_terminal_in = 1'b0;
   logic [15:0] status_first_in = 16'h1234, output_current_in = 16'h0567;
   logic [15:0] status_second_in = 16'h89ab, ramp_selector_switch_in = 16'h0bb8;
   logic [3:0]  address_switch_in = 4'h3, avs_address_in = 4'h0;
   logic [3:0]  avs_byteenable_in = 4'hf;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
   logic        fault_clear_out;
   int          bad_count = 0, n_tests = 0, cycles = 0;
   pd_decoder_pkg::out_words_t pd_out_words_in;
   pd_decoder_pkg::in_words_t  pd_in_words_out;
   pd_decoder_pkg::drive_cmd_t drive_cmd_out;
   drive_process_data_decoder u_drive_process_data_decoder (.*);
   fieldbus_master_model u_fieldbus_master_model (.clk_in(clk_in),
      .words_out(pd_out_words_in), .valid_out(pd_valid_in));
   initial
   begin
      forever #25 clk_in = ~clk_in;
   end
   task automatic chk(input logic [47:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus
   task automatic t_enable();
      u_fieldbus_master_model.send(16'h0006, 16'h4000, 16'h0);
      chk(drive_cmd_out[34:16], {3'b100, 16'h4000});
      u_fieldbus_master_model.send(16'hffb6, 16'hc000, 16'h0);
      chk(drive_cmd_out[34:16], {3'b100, 16'hc000});
      clockwise_terminal_in <= 1'b0;
      counterclockwise_terminal_in <= 1'b1;
      u_fieldbus_master_model.send(16'h0006, 16'hccc5, 16'h0);
      chk(drive_cmd_out[34:16], {3'b100, 16'hccc5});
      counterclockwise_terminal_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk(drive_cmd_out.enable, 1'b0);
      clockwise_terminal_in <= 1'b1;
      u_fieldbus_master_model.send(16'h0006, 16'h0100, 16'h0);
      u_fieldbus_master_model.stop();
      chk(drive_cmd_out[34:32], 3'b010);
      u_fieldbus_master_model.send(16'h0006, 16'h0100, 16'h0);
      u_fieldbus_master_model.send(16'h0003, 16'h0100, 16'h0);
      chk(drive_cmd_out[34:32], 3'b010);
      address_switch_in <= 4'h0;
      u_fieldbus_master_model.send(16'h0006, 16'h1111, 16'h0);
      chk(drive_cmd_out[34:16], {3'b010, 16'h0100});
      address_switch_in <= 4'h3;
   endtask : t_enable
   task automatic t_fault();
      u_fieldbus_master_model.send(16'h0040, 16'h0, 16'h0);
      chk(fault_clear_out, 1'b0);
      fault_in <= 1'b1;
      u_fieldbus_master_model.send(16'h0040, 16'h0, 16'h0);
      chk({fault_clear_out, drive_cmd_out.fault_ack}, 2'b11);
      @(posedge clk_in);
      #1 chk(fault_clear_out, 1'b0);
   endtask : t_fault
   task automatic t_ramp();
      logic [15:0] r [3] = '{16'h0032, 16'h3000, 16'h07d0};
      logic [15:0] e [3] = '{16'h0064, 16'h2710, 16'h07d0};
      chk(drive_cmd_out.ramp_ms, 16'h0bb8);
      bus(1'b0, 4'h1, 32'hffff_ffff);
      chk(rd, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      foreach (r[i])
      begin
         u_fieldbus_master_model.send(16'h0006, 16'h0, r[i]);
         chk(drive_cmd_out.ramp_ms, e[i]);
      end
      chk(pd_in_words_out, 48'h1234_0567_89ab);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h07d0);
      bus(1'b1, 4'h0, 32'h0);
      repeat (2) @(posedge clk_in);
      #1 chk(pd_in_words_out, 48'h1234_0567_0000);
   endtask : t_ramp
   task automatic t_bus();
      u_fieldbus_master_model.send(16'h0006, 16'h2000, 16'h0);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0000_2000);
      bus(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0000_0033);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0000_0bb8);
      avs_byteenable_in <= 4'h0;
      bus(1'b1, 4'h0, 32'h1);
      avs_byteenable_in <= 4'hf;
      bus(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h0);
   endtask : t_bus
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      #1 chk(drive_cmd_out, {3'b010, 16'h0, 16'h03e8});
      t_enable();
      t_fault();
      t_ramp();
      t_bus();
      report_and_stop();
   end
endmodule : drive_process_data_decoder_test
`default_nettype wire
